//--- src/toe_top.sv
// Input frame offset alignment and output enable indication for a 64-stream switch.
// Register map, one 16-bit word per address.
// Words 0x00 to 0x0F hold the receive offset codes, four streams to a word.
// Stream s lives in word s/4, in the nibble that starts at bit 4*(s%4).
// Within a stream nibble, bits 3:1 are the offset count and bit 0 the half-cycle select.
// Words 0x10 and 0x11 hold the receive group rates, four groups to a word.
// Words 0x12 and 0x13 hold the transmit group rates and group drive enables.
// Group g lives in word 0x10+g/4 (receive) or 0x12+g/4 (transmit), in nibble g%4.
// Within a group nibble, bits 2:0 are the rate code and bit 3 the drive enable.
// The drive enable bit of a receive group is stored and read back but has no effect.
// Word 0x14 is read-only and returns the live frame position in half master clocks.
// Writes to any other address are dropped and reads of them return zero.
// Every register resets to zero: no offset, 2.048 Mb/s, and every group floated.
//
// Register port timing.
// A write takes effect at the clock edge that samples the write strobe.
// Read data appear in the cycle after the read strobe and only in that cycle.
// Outside that cycle the read data port rests at zero.
// Strobes may come back to back, and the port never stalls the master.
//
// Rate codes.
// Code 0 is 2.048, 1 is 4.096, 2 is 8.192, 3 is 16.384 and 4 is 32.768 Mb/s.
// Codes 5 and 6 behave as 2.048 Mb/s.
// Code 7 selects enable indication on an odd transmit group and 2.048 Mb/s elsewhere.
//
// Frame position.
// The master bit clock and the frame pulse are sampled as data by the system clock.
// Each level of the master clock must therefore last at least one system cycle.
// A rising master edge that sees the frame pulse low restarts the count at zero.
// Every other master edge, rising or falling, advances the count by one.
// The count is 13 bits wide, enough for a full frame of 4096 master clocks.
// A missing frame pulse is tolerated: the count wraps and sampling goes on.
//
// Receive alignment.
// The delay of a stream is its 4-bit code shifted left by a rate-dependent step.
// The step is 0 at 32 Mb/s, 1 at 16 and 8 Mb/s, 2 at 4 Mb/s and 3 at 2 Mb/s.
// Delay and bit cells are both counted in half master clocks.
// A bit cell is 2, 4, 8, 16 or 32 half clocks long, from 32 down to 2 Mb/s.
// Each cell is sampled at its middle, which keeps the sample away from both cell edges.
// Even codes at 32 Mb/s therefore sample on the rising master edge, odd codes on the falling.
// The sampled bit, a one-cycle strobe and a frame start flag leave one cycle later.
// The frame start flag rides on the strobe of bit cell zero of the delayed frame.
// Changing a code mid-frame can drop or repeat several bit cells of that stream.
//
// Transmit control.
// A stream drives when its group enable and its per-channel request are both set.
// An odd group beside a 32 Mb/s even group is floated unless it indicates.
// An odd group with code 7 carries the drive state of the stream eight below, bit by bit.
// The indication group itself drives whenever its own group enable is set.
// Data and enable of every stream share one register stage.
// Because of that, an indication bit leaves in the same cycle as the enable it reports.
// An even group never reads its odd partner, so its data never depend on it.
// The outputs change one system cycle after the inputs that cause them.
//
// Limitations.
// The block works in system clock time, not at the serial bit rate of the pins.
// Serialisation, switching memories and bit error testing live outside this block.
// A master clock faster than half the system clock loses edges.
// The frame pulse is only looked at on rising master edges, so a short pulse can be missed.
// Rate changes take effect at once and may corrupt the frame in flight.
// The status word is a plain snapshot and may move between two reads.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module toe_top
  import toe_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic [toe_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic [toe_pkg::DATA_W-1:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [toe_pkg::DATA_W-1:0] O_REG_RDATA,
  input wire logic I_MASTER_BIT_CLOCK_IN,
  input wire logic I_FRAME_PULSE_IN_N,
  input wire logic [toe_pkg::NUM_STREAMS-1:0] I_RX,
  output logic [toe_pkg::NUM_STREAMS-1:0] O_RX_BIT,
  output logic [toe_pkg::NUM_STREAMS-1:0] O_RX_STROBE,
  output logic [toe_pkg::NUM_STREAMS-1:0] O_RX_FRAME_START,
  input wire logic [toe_pkg::NUM_STREAMS-1:0] I_TX_DATA,
  input wire logic [toe_pkg::NUM_STREAMS-1:0] I_TX_CH_OE,
  output logic [toe_pkg::NUM_STREAMS-1:0] O_TX_DATA,
  output logic [toe_pkg::NUM_STREAMS-1:0] O_TX_OE
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [DATA_W-1:0] ofs_q [NUM_OFS_REGS];
  logic [DATA_W-1:0] ofs_d [NUM_OFS_REGS];
  logic [DATA_W-1:0] rx_rate_q [2];
  logic [DATA_W-1:0] rx_rate_d [2];
  logic [DATA_W-1:0] tx_rate_q [2];
  logic [DATA_W-1:0] tx_rate_d [2];
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [HALF_CNT_W-1:0] half_cnt_q;

  // Writes land in the addressed word; reads answer one cycle later, unmapped as zero.
  always_comb begin
    for (int i = 0; i < NUM_OFS_REGS; i++) begin
      ofs_d[i] = ofs_q[i];
    end
    for (int i = 0; i < 2; i++) begin
      rx_rate_d[i] = rx_rate_q[i];
      tx_rate_d[i] = tx_rate_q[i];
    end
    if (I_REG_WR) begin
      if (I_REG_ADDR < ADDR_RX_RATE0) begin
        ofs_d[I_REG_ADDR[3:0]] = I_REG_WDATA;
      end else if (I_REG_ADDR == ADDR_RX_RATE0) begin
        rx_rate_d[0] = I_REG_WDATA;
      end else if (I_REG_ADDR == ADDR_RX_RATE1) begin
        rx_rate_d[1] = I_REG_WDATA;
      end else if (I_REG_ADDR == ADDR_TX_RATE0) begin
        tx_rate_d[0] = I_REG_WDATA;
      end else if (I_REG_ADDR == ADDR_TX_RATE1) begin
        tx_rate_d[1] = I_REG_WDATA;
      end
    end
    rdata_d = 16'h0000;
    if (I_REG_RD) begin
      if (I_REG_ADDR < ADDR_RX_RATE0) begin
        rdata_d = ofs_q[I_REG_ADDR[3:0]];
      end else if (I_REG_ADDR == ADDR_RX_RATE0) begin
        rdata_d = rx_rate_q[0];
      end else if (I_REG_ADDR == ADDR_RX_RATE1) begin
        rdata_d = rx_rate_q[1];
      end else if (I_REG_ADDR == ADDR_TX_RATE0) begin
        rdata_d = tx_rate_q[0];
      end else if (I_REG_ADDR == ADDR_TX_RATE1) begin
        rdata_d = tx_rate_q[1];
      end else if (I_REG_ADDR == ADDR_STATUS) begin
        rdata_d = DATA_W'(half_cnt_q);
      end
    end
  end

  // Register storage; read data is a one-cycle pulse of the addressed word.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int i = 0; i < NUM_OFS_REGS; i++) begin
        ofs_q[i] <= OFS_RESET;
      end
      for (int i = 0; i < 2; i++) begin
        rx_rate_q[i] <= RATE_RESET;
        tx_rate_q[i] <= RATE_RESET;
      end
      rdata_q <= 16'h0000;
    end else begin
      for (int i = 0; i < NUM_OFS_REGS; i++) begin
        ofs_q[i] <= ofs_d[i];
      end
      for (int i = 0; i < 2; i++) begin
        rx_rate_q[i] <= rx_rate_d[i];
        tx_rate_q[i] <= tx_rate_d[i];
      end
      rdata_q <= rdata_d;
    end
  end

  assign O_REG_RDATA = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame position counter in master clock half periods.

  logic mclk_q;
  logic mclk_d;
  logic mclk_edge;
  logic mclk_rise;
  logic [HALF_CNT_W-1:0] half_cnt_d;

  // The master clock is sampled as data, so it must run at no more than half the system clock.
  always_comb begin
    mclk_d = I_MASTER_BIT_CLOCK_IN;
    mclk_rise = I_MASTER_BIT_CLOCK_IN && !mclk_q;
    mclk_edge = I_MASTER_BIT_CLOCK_IN != mclk_q;
    half_cnt_d = half_cnt_q;
    if (mclk_rise && !I_FRAME_PULSE_IN_N) begin
      half_cnt_d = '0;
    end else if (mclk_edge) begin
      half_cnt_d = half_cnt_q + HALF_CNT_W'(1);
    end
  end

  // Counter and clock history.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      mclk_q <= 1'b0;
      half_cnt_q <= '0;
    end else begin
      mclk_q <= mclk_d;
      half_cnt_q <= half_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive stream alignment, one sampler per stream.

  for (genvar s = 0; s < NUM_STREAMS; s++) begin : g_rx
    localparam int unsigned REG = s / FIELDS_PER_REG;
    localparam int unsigned LSB = (s % FIELDS_PER_REG) * NIBBLE_W;
    localparam int unsigned GRP = s / GROUP_SIZE;
    localparam int unsigned RLSB = (GRP % FIELDS_PER_REG) * NIBBLE_W + RATE_LSB;
    logic [3:0] code;
    logic [2:0] rate;
    // Nibble is offset bits 3:1 and half-cycle select at bit 0.
    assign code = ofs_q[REG][LSB +: NIBBLE_W];
    assign rate = rx_rate_q[GRP / FIELDS_PER_REG][RLSB +: RATE_W];
    toe_rx_align u_align (
      .i_clk(I_CLK_SYS),
      .i_nrst(I_NRST),
      .i_edge(mclk_edge),
      .i_half_cnt(half_cnt_q),
      .i_code(code),
      .i_rate(rate),
      .i_rx(I_RX[s]),
      .o_bit(O_RX_BIT[s]),
      .o_strobe(O_RX_STROBE[s]),
      .o_first(O_RX_FRAME_START[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit drive control and enable indication.

  logic [NUM_STREAMS-1:0] drive;
  logic [NUM_STREAMS-1:0] tx_data_d;
  logic [NUM_STREAMS-1:0] tx_data_q;
  logic [NUM_STREAMS-1:0] tx_oe_d;
  logic [NUM_STREAMS-1:0] tx_oe_q;

  for (genvar s = 0; s < NUM_STREAMS; s++) begin : g_tx
    localparam int unsigned GRP = s / GROUP_SIZE;
    localparam int unsigned FLD = (GRP % FIELDS_PER_REG) * NIBBLE_W;
    localparam int unsigned PGRP = GRP ^ 1;
    localparam int unsigned PFLD = (PGRP % FIELDS_PER_REG) * NIBBLE_W;
    localparam bit ODD = (GRP % 2) == 1;
    logic [2:0] rate;
    logic [2:0] pair_rate;
    logic grp_oe;
    logic ind_mode;
    logic blocked;
    assign rate = tx_rate_q[GRP / FIELDS_PER_REG][FLD + RATE_LSB +: RATE_W];
    assign pair_rate = tx_rate_q[PGRP / FIELDS_PER_REG][PFLD + RATE_LSB +: RATE_W];
    assign grp_oe = tx_rate_q[GRP / FIELDS_PER_REG][FLD + GROUP_OE_BIT];
    // Code 111 on an even group is not honoured, so the group falls back to plain data.
    assign ind_mode = ODD && (rate == RATE_IND);
    // An odd group beside a 32 Mb/s even group is only usable as an indication.
    assign blocked = ODD && !ind_mode && (pair_rate == RATE_32M);
    // Drive state from the group enable and the per-channel enable of the switch core.
    assign drive[s] = grp_oe && I_TX_CH_OE[s] && !blocked;
    if (ODD) begin : g_odd
      // Indication shows the even stream's drive state instead of any switched data.
      assign tx_data_d[s] = ind_mode ? drive[s - GROUP_SIZE] : I_TX_DATA[s];
      // In indication mode the whole stream follows the group enable only.
      assign tx_oe_d[s] = ind_mode ? (grp_oe && !blocked) : drive[s];
    end else begin : g_even
      // Even streams never look at their odd partner, so toggling it leaves them alone.
      assign tx_data_d[s] = I_TX_DATA[s];
      assign tx_oe_d[s] = drive[s];
    end
  end

  // Data and enables share one register stage, so the indication lines up with its stream.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_data_q <= '0;
      tx_oe_q <= '0;
    end else begin
      tx_data_q <= tx_data_d;
      tx_oe_q <= tx_oe_d;
    end
  end

  assign O_TX_DATA = tx_data_q;
  assign O_TX_OE = tx_oe_q;

endmodule
`default_nettype wire

//--- src/toe_pkg.sv
// Package with register map, field layout and rate codes of the offset and enable-indication block.
package toe_pkg;

  // Register port widths, stream and group sizes, and the number of offset words.
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_STREAMS = 64;
  localparam int unsigned NUM_GROUPS = 8;
  localparam int unsigned GROUP_SIZE = 8;
  localparam int unsigned NUM_OFS_REGS = 16;

  // Register word addresses.
  localparam logic [4:0] ADDR_OFS_BASE = 5'h00;
  localparam logic [4:0] ADDR_RX_RATE0 = 5'h10;
  localparam logic [4:0] ADDR_RX_RATE1 = 5'h11;
  localparam logic [4:0] ADDR_TX_RATE0 = 5'h12;
  localparam logic [4:0] ADDR_TX_RATE1 = 5'h13;
  localparam logic [4:0] ADDR_STATUS = 5'h14;

  // Reset values of every register.
  localparam logic [15:0] OFS_RESET = 16'h0000;
  localparam logic [15:0] RATE_RESET = 16'h0000;

  // Field layout: each stream or group owns one nibble of a register.
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned FIELDS_PER_REG = 4;
  localparam int unsigned RATE_LSB = 0;
  localparam int unsigned RATE_W = 3;
  localparam int unsigned GROUP_OE_BIT = 3;
  localparam int unsigned HALF_SEL_BIT = 0;

  // Group rate codes.
  localparam logic [2:0] RATE_2M = 3'h0;
  localparam logic [2:0] RATE_4M = 3'h1;
  localparam logic [2:0] RATE_8M = 3'h2;
  localparam logic [2:0] RATE_16M = 3'h3;
  localparam logic [2:0] RATE_32M = 3'h4;
  localparam logic [2:0] RATE_IND = 3'h7;

  // Frame position counter in master clock half periods (4096 periods per frame).
  localparam int unsigned HALF_CNT_W = 13;

  // Shift that scales one delay code step into half periods of the master clock.
  function automatic logic [1:0] step_shift(input logic [2:0] rate);
    case (rate)
      RATE_32M: step_shift = 2'd0;
      RATE_16M: step_shift = 2'd1;
      RATE_8M: step_shift = 2'd1;
      RATE_4M: step_shift = 2'd2;
      default: step_shift = 2'd3;
    endcase
  endfunction

  // Log2 of one bit period in half periods of the master clock.
  function automatic logic [2:0] bit_lg(input logic [2:0] rate);
    case (rate)
      RATE_32M: bit_lg = 3'd1;
      RATE_16M: bit_lg = 3'd2;
      RATE_8M: bit_lg = 3'd3;
      RATE_4M: bit_lg = 3'd4;
      default: bit_lg = 3'd5;
    endcase
  endfunction

endpackage

//--- src/toe_rx_align.sv
// One receive stream sampler with programmable frame offset.
`timescale 1ns/1ps
`default_nettype none
module toe_rx_align
  import toe_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_edge,
  input wire logic [toe_pkg::HALF_CNT_W-1:0] i_half_cnt,
  input wire logic [3:0] i_code,
  input wire logic [2:0] i_rate,
  input wire logic i_rx,
  output logic o_bit,
  output logic o_strobe,
  output logic o_first
);

  logic [HALF_CNT_W-1:0] delay;
  logic [HALF_CNT_W-1:0] local_pos;
  logic [HALF_CNT_W-1:0] bit_mask;
  logic [HALF_CNT_W-1:0] mid_point;
  logic [HALF_CNT_W-1:0] bit_index;
  logic sample;
  logic bit_d;
  logic strobe_d;
  logic first_d;
  logic bit_q;
  logic strobe_q;
  logic first_q;

  // Delay code is offset bits above the half-cycle select; code zero gives no delay.
  always_comb begin
    delay = HALF_CNT_W'({9'h000, i_code}) << step_shift(i_rate);
    local_pos = i_half_cnt - delay;
    bit_mask = (HALF_CNT_W'(1) << bit_lg(i_rate)) - HALF_CNT_W'(1);
    mid_point = HALF_CNT_W'(1) << (bit_lg(i_rate) - 3'd1);
    bit_index = local_pos >> bit_lg(i_rate);
    // Sample in the middle of each delayed bit cell, so half steps land on the other edge.
    sample = i_edge && ((local_pos & bit_mask) == mid_point);
    bit_d = sample ? i_rx : bit_q;
    strobe_d = sample;
    first_d = sample && (bit_index == '0);
  end

  // Sampled bit holds until the next sample point.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_q <= 1'b0;
      strobe_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
      strobe_q <= strobe_d;
      first_q <= first_d;
    end
  end

  assign o_bit = bit_q;
  assign o_strobe = strobe_q;
  assign o_first = first_q;

endmodule
`default_nettype wire

//--- dv/toe_tdm_far.sv
// Far-side backplane model: master bit clock, frame pulse and receive streams.
`timescale 1ns/1ps
`default_nettype none
module toe_tdm_far (
  input wire logic i_clk,
  input wire logic i_nrst,
  output logic o_mclk,
  output logic o_fp_n,
  output logic [63:0] o_rx
);
  logic [9:0] cnt_q;
  // Four system cycles per clock level and 128 clocks a frame, so many frames fit in one run.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end
  // The backplane clock runs free; the pulse spans the first rising edge of a frame.
  assign o_mclk = cnt_q[2];
  assign o_fp_n = |cnt_q[9:3];
  assign o_rx = {32{cnt_q[4], cnt_q[3]}};
endmodule
`default_nettype wire

//--- dv/toe_chk.sv
// Port-level checks of the offset and enable-indication block.
`timescale 1ns/1ps
`default_nettype none
module toe_chk
  import toe_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic [4:0] I_REG_ADDR,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [15:0] O_REG_RDATA,
  input wire logic [63:0] O_RX_STROBE,
  input wire logic [63:0] O_RX_FRAME_START,
  input wire logic [63:0] I_TX_DATA,
  input wire logic [63:0] I_TX_CH_OE,
  input wire logic [63:0] O_TX_DATA,
  input wire logic [63:0] O_TX_OE
);
  logic [31:0] tx_q;
  logic ind1;
  logic blk1;
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the transmit rate words, so group settings can be judged at the pins.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_q <= 32'h0000_0000;
    end else if (I_REG_WR && I_REG_ADDR == ADDR_TX_RATE0) begin
      tx_q[15:0] <= I_REG_WDATA;
    end else if (I_REG_WR && I_REG_ADDR == ADDR_TX_RATE1) begin
      tx_q[31:16] <= I_REG_WDATA;
    end
  end
  // Group 1 either indicates for group 0 or is floated behind a 32 Mb/s group 0.
  assign ind1 = tx_q[6:4] == RATE_IND;
  assign blk1 = tx_q[2:0] == RATE_32M && !ind1;
  ////////////////////////////////////////////////////////////////////////////////
  default clocking chk_cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  ind_data_a: assert property ($past(ind1) |-> O_TX_DATA[15:8] == O_TX_OE[7:0])
    else $error("indication differs from group 0 drive");
  ind_oe_a: assert property ($past(ind1) |-> O_TX_OE[15:8] == {8{$past(tx_q[7])}})
    else $error("indication group enable wrong");
  blk_float_a: assert property ($past(blk1) |-> O_TX_OE[15:8] == 8'h00)
    else $error("blocked odd group drives");
  grp_oe_a: assert property (O_TX_OE[7:0] == ({8{$past(tx_q[3])}} & $past(I_TX_CH_OE[7:0])))
    else $error("group 0 enable wrong");
  grp_data_a: assert property ((O_TX_DATA[7:0] & O_TX_OE[7:0]) ==
    ($past(I_TX_DATA[7:0]) & O_TX_OE[7:0])) else $error("group 0 data wrong");
  fs_strobe_a: assert property ((O_RX_FRAME_START & ~O_RX_STROBE) == 64'h0)
    else $error("frame start without strobe");
  stb_pulse_a: assert property (O_RX_STROBE[0] |=> !O_RX_STROBE[0] [*3])
    else $error("strobes closer than a clock edge");
  rd_rate_a: assert property (I_REG_RD && I_REG_ADDR == ADDR_TX_RATE0 |=>
    O_REG_RDATA == $past(tx_q[15:0])) else $error("rate word readback wrong");
  cover property ($past(ind1) && O_TX_OE[8] && O_TX_DATA[8]);
  cover property ($past(blk1) && |$past(I_TX_CH_OE[15:8]));
  cover property (O_RX_FRAME_START[7] && !O_RX_FRAME_START[0]);
endmodule
bind toe_top toe_chk chk (.*);
`default_nettype wire

//--- dv/toe_top_tb.sv
// Self-checking bench of the offset and enable-indication block.
`timescale 1ns/1ps
`default_nettype none
module toe_top_tb;
  import toe_pkg::*;
  logic clk, nrst, wr_s, rd_s, mclk, fpn;
  logic [4:0] addr;
  logic [15:0] wd, rdat;
  logic [63:0] rx, rbit, rstb, rfs, txd, txc, otd, oto, dd, cc;
  logic [31:0] seed;
  int err_count, checks;
  int rc[6] = '{4, 3, 2, 1, 0, 5};
  int sh[6] = '{0, 1, 1, 2, 3, 3};
  logic [15:0] cfg[4] = '{16'h8F08, 16'h8F0C, 16'h847C, 16'h848C};
  toe_top uut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_REG_ADDR(addr), .I_REG_WDATA(wd),
    .I_REG_WR(wr_s), .I_REG_RD(rd_s), .O_REG_RDATA(rdat), .I_MASTER_BIT_CLOCK_IN(mclk),
    .I_FRAME_PULSE_IN_N(fpn), .I_RX(rx), .O_RX_BIT(rbit), .O_RX_STROBE(rstb),
    .O_RX_FRAME_START(rfs), .I_TX_DATA(txd), .I_TX_CH_OE(txc), .O_TX_DATA(otd), .O_TX_OE(oto));
  toe_tdm_far far (.i_clk(clk), .i_nrst(nrst), .o_mclk(mclk), .o_fp_n(fpn), .o_rx(rx));
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 50 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(64'(rdat), 64'(e));
  endtask
  // Bounded wait for the next frame start of stream 0.
  task automatic wfs();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rfs[0] !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      err_count++;
      summarize();
    end
  endtask
  // Transmit model: an odd group in indication mode shows its even group's drive state.
  function automatic void tx_exp(input logic [31:0] r, input logic [63:0] d, input logic [63:0] c,
                                 output logic [63:0] eo, output logic [63:0] ed,
                                 output logic [63:0] m);
    int g;
    for (int s = 0; s < 64; s++) begin
      g = s / 8;
      if (g % 2 == 1 && r[g*4+:3] == 3'h7) begin
        eo[s] = r[g*4+3];
        ed[s] = r[g*4-1] & c[s-8];
        m[s] = 1'b1;
      end else if (g % 2 == 1 && r[g*4-4+:3] == 3'h4) begin
        eo[s] = 1'b0;
        ed[s] = 1'b0;
        m[s] = 1'b0;
      end else begin
        eo[s] = r[g*4+3] & c[s];
        ed[s] = d[s];
        m[s] = eo[s];
      end
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: registers, receive offsets per rate, then transmit groups.
  initial begin
    int tm[8];
    logic [31:0] r, w;
    logic [63:0] eo, ed, m, nd, nc;
    nrst = 1'b0;
    addr = 5'h00;
    wd = 16'h0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    txd = 64'h0;
    txc = 64'h0;
    dd = 64'h0;
    cc = 64'h0;
    seed = 32'h0001_0E27;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_OFS_BASE, OFS_RESET);
    rd(ADDR_TX_RATE0, RATE_RESET);
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000);
    wr(ADDR_OFS_BASE, 16'hF810);
    rd(ADDR_OFS_BASE, 16'hF810);
    for (int i = 0; i < 6; i++) begin
      w = xs();
      w[15:0] = 16'hF810;
      wr(ADDR_RX_RATE0, {4{1'b0, rc[i][2:0]}});
      wr(ADDR_OFS_BASE + 5'h01, w[31:16]);
      wfs();
      wfs();
      for (int s = 0; s < 8; s++) tm[s] = -1;
      for (int t = 0; t < 600; t++) begin
        for (int s = 0; s < 8; s++) if (rfs[s] === 1'b1 && tm[s] < 0) tm[s] = t;
        // The pin level before the edge is what a sample at that edge must return.
        nd = rx;
        @(posedge clk);
        #1;
        for (int s = 0; s < 8; s++) if (rstb[s] === 1'b1) chk(64'(rbit[s]), 64'(nd[s]));
      end
      for (int s = 1; s < 8; s++) chk(64'(tm[s]), 64'((int'(w[4*s+:4]) << sh[i]) * 4));
    end
    for (int k = 0; k < 6; k++) begin
      r = xs();
      if (k < 4) r[15:0] = cfg[k];
      wr(ADDR_TX_RATE0, r[15:0]);
      wr(ADDR_TX_RATE1, r[31:16]);
      rd(ADDR_TX_RATE1, r[31:16]);
      for (int t = 0; t < 40; t++) begin
        @(posedge clk);
        nd = {xs(), xs()};
        nc = {xs(), xs()};
        txd <= nd;
        txc <= nc;
        #1;
        tx_exp(r, dd, cc, eo, ed, m);
        chk(oto, eo);
        chk(otd & m, ed & m);
        dd = nd;
        cc = nc;
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
